// [include/mid_defs.svh]
/*
 * constants for the move-group instruction decoder: opcode patterns,
 * field positions and reset values.
 * assumes 12-bit instruction words and 8-bit data.
 */
`ifndef MID_DEFS_SVH
`define MID_DEFS_SVH

`define MID_COPY_MASK      12'hFC0
`define MID_COPY_PAT       12'h200
`define MID_STORE_MASK     12'hFE0
`define MID_STORE_PAT      12'h020
`define MID_LIT_MASK       12'hF00
`define MID_LIT_PAT        12'hC00
`define MID_IDLE_PAT       12'h000
`define MID_OPTION_PAT     12'h002
`define MID_DEST_BIT       5
`define MID_IDX_HI         4
`define MID_LIT_HI         7
`define MID_ACC_RESET      8'h00
`define MID_OPTION_RESET   8'hFF
`define MID_ZERO_RESET     1'b0
`define MID_ZERO_DATA      8'h00

`endif

// [include/mid_pkg.sv]
/*
 * types for the move-group instruction decoder.
 * assumes mid_defs.svh is on the include path.
 */
package mid_pkg;

    typedef enum logic [2:0] {
        MID_OP_NONE,
        MID_OP_COPY,
        MID_OP_STORE,
        MID_OP_LIT,
        MID_OP_IDLE,
        MID_OP_OPTION
    } mid_op_t;

    // file register write request towards the register file
    typedef struct packed {
        logic       en;
        logic [4:0] idx;
        logic [7:0] data;
    } mid_fwr_t;

endpackage

// [rtl/mid_decode.sv]
/*
 * move-group instruction decoder and executor: decodes one 12-bit word
 * per enabled cycle and updates accumulator, zero flag, option register
 * and the file register write port.
 * assumes the register file answers file_rd_data combinationally for
 * file_rd_idx, and instr comes from same-clock fetch logic.
 */
// Operation
// - copy-register op 0010_00df_ffff decoded and executed in one cycle
// - register index 0..31, one destination bit
// - destination bit clear: register value goes to accumulator
// - destination bit set: value written back, accumulator kept
// - copy updates zero flag from moved value, nothing else
// - 0000_001f_ffff stores accumulator to register, flags untouched
`timescale 1ns/1ps
`include "mid_defs.svh"

module mid_decode
    import mid_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        instr_valid,
    input  wire logic [11:0] instr,
    output logic      [4:0]  file_rd_idx,
    input  wire logic [7:0]  file_rd_data,
    output mid_fwr_t         file_wr,
    output logic      [7:0]  acc_q,
    output logic             zero_q,
    output logic      [7:0]  option_q,
    output logic             unknown_op
);

    ////////////////////////////////////////////////////////////////////
    // decoded fields and strobes
    mid_op_t    op;
    logic       dest;
    logic [4:0] idx;
    logic [7:0] literal;
    logic       go;
    logic       is_copy;
    logic       is_store;
    logic       is_lit;
    logic       is_option;
    logic       copy_to_acc;
    logic       copy_to_file;
    logic [7:0] acc_d;
    logic       zero_d;
    logic [7:0] option_d;
    mid_fwr_t   fwr_d;

    assign dest        = instr[`MID_DEST_BIT];
    assign idx         = instr[`MID_IDX_HI:0];
    assign literal     = instr[`MID_LIT_HI:0];
    // read address follows the word as is; the register file answers
    // in the same cycle, so a copy needs no wait state
    assign file_rd_idx = idx;
    // ce gates the strobe so a frozen cycle neither executes nor flags
    assign go          = ce && instr_valid;

    // exact patterns first so the option word is not taken as anything else
    always_comb begin
        if (instr == `MID_IDLE_PAT) begin
            op = MID_OP_IDLE;
        end else if (instr == `MID_OPTION_PAT) begin
            op = MID_OP_OPTION;
        end else if ((instr & `MID_COPY_MASK) == `MID_COPY_PAT) begin
            op = MID_OP_COPY;
        end else if ((instr & `MID_STORE_MASK) == `MID_STORE_PAT) begin
            op = MID_OP_STORE;
        end else if ((instr & `MID_LIT_MASK) == `MID_LIT_PAT) begin
            op = MID_OP_LIT;
        end else begin
            op = MID_OP_NONE;
        end
    end

    // one strobe per op except idle, each already qualified by ce and instr_valid
    assign is_copy      = go && (op == MID_OP_COPY);
    assign is_store     = go && (op == MID_OP_STORE);
    assign is_lit       = go && (op == MID_OP_LIT);
    assign is_option    = go && (op == MID_OP_OPTION);
    assign copy_to_acc  = is_copy && !dest;
    assign copy_to_file = is_copy && dest;

    // words outside this group are only flagged; the core that owns
    // them executes them, this block leaves its state alone
    assign unknown_op   = go && (op == MID_OP_NONE);

    ////////////////////////////////////////////////////////////////////
    // accumulator: literal and copy-to-acc load it, all else keeps it
    always_comb begin
        acc_d = acc_q;
        case (op)
            MID_OP_COPY: begin
                if (copy_to_acc) begin
                    acc_d = file_rd_data;
                end
            end
            MID_OP_LIT: begin
                if (is_lit) begin
                    acc_d = literal;
                end
            end
            MID_OP_IDLE: begin
                acc_d = acc_q;
            end
            default: begin
                acc_d = acc_q;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        // rst is not gated by ce, so a frozen core still resets
        if (rst) begin
            acc_q <= `MID_ACC_RESET;
        end else if (ce) begin
            acc_q <= acc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // zero flag: only the copy op touches it, so a copy of a register
    // onto itself serves as a zero test without disturbing anything
    always_comb begin
        zero_d = zero_q;
        case (op)
            MID_OP_COPY: begin
                if (is_copy) begin
                    zero_d = (file_rd_data == `MID_ZERO_DATA);
                end
            end
            MID_OP_STORE: begin
                zero_d = zero_q;
            end
            MID_OP_LIT: begin
                zero_d = zero_q;
            end
            MID_OP_IDLE: begin
                zero_d = zero_q;
            end
            default: begin
                zero_d = zero_q;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        // rst is not gated by ce, so a frozen core still resets
        if (rst) begin
            zero_q <= `MID_ZERO_RESET;
        end else if (ce) begin
            zero_q <= zero_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // option register: loaded from the accumulator value before the edge
    always_comb begin
        option_d = option_q;
        case (op)
            MID_OP_OPTION: begin
                if (is_option) begin
                    option_d = acc_q;
                end
            end
            default: begin
                option_d = option_q;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        // rst is not gated by ce, so a frozen core still resets
        if (rst) begin
            option_q <= `MID_OPTION_RESET;
        end else if (ce) begin
            option_q <= option_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // file write port, registered: the write lands one edge after the op,
    // so a read of the same register in the next cycle still sees old data
    // unless the register file forwards; traded for a short read path
    always_comb begin
        fwr_d     = file_wr;
        fwr_d.en  = 1'b0;
        fwr_d.idx = idx;
        case (op)
            MID_OP_COPY: begin
                if (copy_to_file) begin
                    fwr_d.en   = 1'b1;
                    fwr_d.data = file_rd_data;
                end
            end
            MID_OP_STORE: begin
                if (is_store) begin
                    fwr_d.en   = 1'b1;
                    fwr_d.data = acc_q;
                end
            end
            MID_OP_IDLE: begin
                fwr_d.en = 1'b0;
            end
            default: begin
                fwr_d.en = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        // rst is not gated by ce, so a frozen core still resets
        if (rst) begin
            file_wr.en   <= 1'b0;
            file_wr.idx  <= '0;
            file_wr.data <= '0;
        end else if (ce) begin
            file_wr <= fwr_d;
        end
    end

endmodule

// [bench/mid_regfile_model.sv]
/* register file partner: async read, write on file_wr.en */
`timescale 1ns/1ps
module mid_regfile_model import mid_pkg::*; (input wire logic clk,
input wire logic [4:0] file_rd_idx, output logic [7:0] file_rd_data,
input wire mid_fwr_t file_wr);
logic [7:0] m [32];
initial for (int i = 0; i < 32; i++) m[i] = 8'(i * 7);
assign file_rd_data = m[file_rd_idx];
always @(posedge clk) if (file_wr.en) m[file_wr.idx] <= file_wr.data;
endmodule

// [bench/mid_checker.sv]
/* port assertions for mid_decode; bound from the bench top */
`timescale 1ns/1ps
module mid_checker import mid_pkg::*; (input wire logic clk, rst, ce,
instr_valid, zero_q, unknown_op, input wire logic [11:0] instr,
input wire logic [4:0] file_rd_idx, input wire mid_fwr_t file_wr,
input wire logic [7:0] file_rd_data, acc_q, option_q);
default clocking @(posedge clk); endclocking
default disable iff (rst);
wire ok = ce && instr_valid, cp = instr[11:6] == 6'h08;
wire st = instr[11:5] == 7'h01, li = instr[11:8] == 4'hC;
wire [7:0] d = file_rd_data;
property p_c0; ok && cp && !instr[5] |=> acc_q == $past(d) &&
zero_q == ($past(d) == 8'h00); endproperty
a_c0: assert property (p_c0) else $error("c0");
property p_c1; ok && cp && instr[5] |=> acc_q == $past(acc_q) &&
zero_q == ($past(d) == 8'h00) &&
file_wr == {1'b1, $past(instr[4:0]), $past(d)}; endproperty
a_c1: assert property (p_c1) else $error("c1");
property p_st; ok && st |=> $stable(zero_q) &&
file_wr == {1'b1, $past(instr[4:0]), $past(acc_q)}; endproperty
a_st: assert property (p_st) else $error("st");
property p_li; ok && li |=> acc_q == $past(instr[7:0]); endproperty
a_li: assert property (p_li) else $error("li");
property p_op; ok && instr == 12'h002 |=> option_q == $past(acc_q);
endproperty
a_op: assert property (p_op) else $error("op");
property p_ix; file_rd_idx == instr[4:0]; endproperty
a_ix: assert property (p_ix) else $error("ix");
property p_un; ok |-> unknown_op != (cp || st || li ||
instr == 12'h000 || instr == 12'h002); endproperty
a_un: assert property (p_un) else $error("un");
c_c1: cover property (ok && cp && instr[5]);
c_st: cover property (ok && st);
c_op: cover property (ok && instr == 12'h002);
endmodule

// [bench/mid_decode_test.sv]
/* random bench for mid_decode, model compared every cycle */
`timescale 1ns/1ps
module mid_decode_test import mid_pkg::*;;
logic clk = 0, rst = 1, ce = 1, instr_valid = 0, zero_q, unknown_op, z, wen;
logic [11:0] instr = 0;
logic [7:0] file_rd_data, acc_q, option_q, acc, opt, rd, wd, m [32];
logic [4:0] file_rd_idx, wi;
logic [31:0] r;
mid_fwr_t file_wr;
int miscompares = 0, cmp_count = 0, cyc = 0, seed = 55157;
mid_decode mid_decode_i (.*);
mid_regfile_model mid_regfile_model_i (.*);
initial forever #2.5 clk = ~clk;
task automatic chk(string n, logic [13:0] e, logic [13:0] g);
    cmp_count++;
    if (e !== g) begin
        miscompares++;
        $display("Error %s expected %h seen %h", n, e, g);
    end
endtask
task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
endtask
// reset values: accumulator clear, option all ones
task automatic mrst; acc = 0; opt = 8'hFF; z = 0; wen = 0; endtask
always @(posedge clk) if (++cyc > 3000) begin miscompares++; close_out; end
initial begin
    for (int i = 0; i < 32; i++) m[i] = 8'(i * 7);
    mrst;
    repeat (8) @(posedge clk);
    #1 rst = 0;
    for (int n = 0; n < 2000; n++) begin
        r = $random(seed);
        case (r[2:0])
            0: instr = {6'h08, r[10:5]};
            1: instr = {7'h01, r[9:5]};
            2: instr = {4'hC, r[12:5]};
            3: instr = 12'h000;
            4: instr = 12'h002;
            default: instr = r[20:9];
        endcase
        ce = r[31:29] != 0;
        instr_valid = r[28:26] != 0;
        rst = n == 999;
        // write-back lands one edge late, so a copy reads old data
        rd = m[instr[4:0]];
        if (wen) m[wi] = wd;
        if (rst) mrst;
        else if (ce) begin
            wen = 0;
            if (instr_valid && instr[11:6] == 6'h08) begin
                z = rd == 0;
                if (instr[5]) {wen, wi, wd} = {1'b1, instr[4:0], rd};
                else acc = rd;
            end
            if (instr_valid && instr[11:5] == 7'h01)
                {wen, wi, wd} = {1'b1, instr[4:0], acc};
            if (instr_valid && instr[11:8] == 4'hC) acc = instr[7:0];
            if (instr_valid && instr == 12'h002) opt = acc;
        end
        #1 chk("unknown", ce && instr_valid && !(instr[11:6] == 6'h08 ||
            instr[11:5] == 7'h01 || instr[11:8] == 4'hC ||
            instr == 12'h000 || instr == 12'h002), unknown_op);
        @(posedge clk);
        #1;
        chk("acc", acc, acc_q);
        chk("zero", z, zero_q);
        chk("option", opt, option_q);
        chk("write", wen ? {wen, wi, wd} : 0, file_wr.en ? file_wr : 0);
    end
    close_out;
end
endmodule
bind mid_decode mid_checker mid_checker_i (.*);
